// >>> ebm_block_memory.v
// 9-Kbit block memory with RAM, ROM and FIFO modes
`include "ebm_regs.vh"

module ebm_block_memory (
  input  wire                sys_clk_i,
  input  wire                rst_b_i,
  input  wire                cfg_busy_i,
  input  wire                cfg_we_i,
  input  wire [`EBM_BW-1:0]  cfg_addr_i,
  input  wire                cfg_bit_i,
  input  wire [1:0]          mode_i,
  input  wire                rom_i,
  input  wire [2:0]          a_width_i,
  input  wire [2:0]          b_width_i,
  input  wire                a_out_reg_i,
  input  wire                b_out_reg_i,
  input  wire                a_en_i,
  input  wire                a_we_i,
  input  wire [`EBM_AW-1:0]  a_addr_i,
  input  wire [`EBM_DW-1:0]  a_wdata_i,
  input  wire                b_en_i,
  input  wire                b_we_i,
  input  wire [`EBM_AW-1:0]  b_addr_i,
  input  wire [`EBM_DW-1:0]  b_wdata_i,
  output wire [`EBM_DW-1:0]  a_rdata_o,
  output wire [`EBM_DW-1:0]  b_rdata_o,
  output wire                fifo_full_o,
  output wire                fifo_empty_o
);

  // Width code to bits; true dual-port caps at 18
  function [5:0] ebm_width;
    input [2:0] sel;
    input       tdp;
    begin
      case (sel)
        `EBM_W_X1:  ebm_width = 6'd1;
        `EBM_W_X2:  ebm_width = 6'd2;
        `EBM_W_X4:  ebm_width = 6'd4;
        `EBM_W_X9:  ebm_width = 6'd9;
        `EBM_W_X18: ebm_width = 6'd18;
        default:    ebm_width = tdp ? 6'd18 : 6'd36;
      endcase
    end
  endfunction

  // Word address to first bit of the word
  function [`EBM_BW-1:0] ebm_base;
    input [`EBM_AW-1:0] addr;
    input [5:0]         wid;
    reg   [18:0]        prod;
    begin
      prod     = {6'h00, addr} * {13'h0000, wid};
      ebm_base = (prod >= {4'h0, `EBM_MEM_BITS}) ? 14'h3fff : prod[13:0];
    end
  endfunction

  reg                mem [0:`EBM_MEM_LAST];

  wire               is_tdp;
  wire               is_pdp;
  wire               is_fifo;
  wire               is_sp;
  wire               user_ok;
  wire [5:0]         a_w;
  wire [5:0]         b_w;
  wire [`EBM_BW-1:0] wr_ptr;
  wire [`EBM_BW-1:0] rd_ptr;
  wire               push_ok;
  wire               pop_ok;
  wire               a_take;
  wire               b_take;
  wire               a_wr_take;
  wire               b_wr_take;

  reg  [`EBM_BW-1:0] a_base;
  reg  [`EBM_BW-1:0] b_base;
  reg  [`EBM_DW-1:0] a_wd;
  reg  [`EBM_DW-1:0] b_wd;
  reg                a_wr;
  reg                b_wr;
  reg  [5:0]         a_wr_w;
  reg  [5:0]         b_wr_w;
  reg  [`EBM_DW-1:0] a_arr;
  reg  [`EBM_DW-1:0] b_arr;
  reg  [`EBM_DW-1:0] a_q;
  reg  [`EBM_DW-1:0] b_q;

  integer            i;
  integer            j;

  assign is_sp   = (mode_i == `EBM_MODE_SP);
  assign is_tdp  = (mode_i == `EBM_MODE_TDP);
  assign is_pdp  = (mode_i == `EBM_MODE_PDP);
  assign is_fifo = (mode_i == `EBM_MODE_FIFO);
  assign user_ok = ~cfg_busy_i;

  // Each port keeps its own width
  assign a_w = ebm_width(a_width_i, is_tdp);
  assign b_w = ebm_width(b_width_i, is_tdp);

  ebm_fifo_ctrl u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .fifo_mode_i (is_fifo & user_ok),
    .push_i      (a_en_i & a_we_i & ~rom_i),
    .pop_i       (b_en_i),
    .wr_width_i  (a_w),
    .rd_width_i  (b_w),
    .wr_ptr_o    (wr_ptr),
    .rd_ptr_o    (rd_ptr),
    .push_ok_o   (push_ok),
    .pop_ok_o    (pop_ok),
    .full_o      (fifo_full_o),
    .empty_o     (fifo_empty_o)
  );

  // Port A writes in every mode unless rom_i is set, port B only in true dual-port
  assign a_take    = user_ok & (is_fifo ? push_ok : a_en_i);
  assign b_take    = user_ok & (is_fifo ? pop_ok : b_en_i & ~is_sp);
  assign a_wr_take = a_take & a_we_i & ~rom_i;
  assign b_wr_take = b_take & b_we_i & ~rom_i & is_tdp;

  // Input registers in front of the array
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_base <= 14'h0000;
      b_base <= 14'h0000;
      a_wd   <= 36'h000000000;
      b_wd   <= 36'h000000000;
      a_wr   <= 1'b0;
      b_wr   <= 1'b0;
      a_wr_w <= 6'h00;
      b_wr_w <= 6'h00;
    end else begin
      a_wr <= a_wr_take;
      b_wr <= b_wr_take;
      if (a_take) begin
        a_base <= is_fifo ? wr_ptr : ebm_base(a_addr_i, a_w);
        a_wd   <= a_wdata_i;
        a_wr_w <= a_w;
      end
      if (b_take) begin
        b_base <= is_fifo ? rd_ptr : ebm_base(b_addr_i, b_w);
        b_wd   <= b_wdata_i;
        b_wr_w <= b_w;
      end
    end
  end

  // Array writes; port A wins on a shared bit unless its base lies above port B's
  always @(posedge sys_clk_i) begin
    if (cfg_busy_i) begin
      if (cfg_we_i && ({1'b0, cfg_addr_i} < `EBM_MEM_BITS)) begin
        mem[cfg_addr_i] <= cfg_bit_i;
      end
    end else begin
      for (i = 0; i < `EBM_DW; i = i + 1) begin
        if (b_wr && (i < b_wr_w) &&
            ({1'b0, b_base} + i[14:0] < `EBM_MEM_BITS)) begin
          mem[b_base + i[13:0]] <= b_wd[i];
        end
        if (a_wr && (i < a_wr_w) &&
            ({1'b0, a_base} + i[14:0] < `EBM_MEM_BITS)) begin
          mem[a_base + i[13:0]] <= a_wd[i];
        end
      end
    end
  end

  // Flow-through read from the captured base
  always @* begin
    a_arr = 36'h000000000;
    b_arr = 36'h000000000;
    for (j = 0; j < `EBM_DW; j = j + 1) begin
      if ((j < a_w) && ({1'b0, a_base} + j[14:0] < `EBM_MEM_BITS)) begin
        a_arr[j] = mem[a_base + j[13:0]];
      end
      if ((j < b_w) && ({1'b0, b_base} + j[14:0] < `EBM_MEM_BITS)) begin
        b_arr[j] = mem[b_base + j[13:0]];
      end
    end
  end

  // Optional output register
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_q <= 36'h000000000;
      b_q <= 36'h000000000;
    end else begin
      a_q <= a_arr;
      b_q <= b_arr;
    end
  end

  assign a_rdata_o = a_out_reg_i ? a_q : a_arr;
  assign b_rdata_o = b_out_reg_i ? b_q : b_arr;

endmodule

// >>> ebm_regs.vh
// Constants for the embedded block memory
`ifndef EBM_REGS_VH
`define EBM_REGS_VH

`define EBM_MEM_BITS      15'd9216
`define EBM_CAP_BIN       15'd8192
`define EBM_CAP_NINE      15'd9216
`define EBM_MEM_LAST      9215

`define EBM_MODE_SP       2'h0
`define EBM_MODE_TDP      2'h1
`define EBM_MODE_PDP      2'h2
`define EBM_MODE_FIFO     2'h3

`define EBM_W_X1          3'h0
`define EBM_W_X2          3'h1
`define EBM_W_X4          3'h2
`define EBM_W_X9          3'h3
`define EBM_W_X18         3'h4
`define EBM_W_X36         3'h5

`define EBM_DW            36
`define EBM_AW            13
`define EBM_BW            14

`endif

// >>> ebm_fifo_ctrl.v
// Hard pointer and flag logic for the block memory FIFO mode
`include "ebm_regs.vh"

module ebm_fifo_ctrl (
  input  wire                sys_clk_i,
  input  wire                rst_b_i,
  input  wire                fifo_mode_i,
  input  wire                push_i,
  input  wire                pop_i,
  input  wire [5:0]          wr_width_i,
  input  wire [5:0]          rd_width_i,
  output reg  [`EBM_BW-1:0]  wr_ptr_o,
  output reg  [`EBM_BW-1:0]  rd_ptr_o,
  output wire                push_ok_o,
  output wire                pop_ok_o,
  output wire                full_o,
  output wire                empty_o
);

  reg  [14:0] level;
  reg  [14:0] next_level;
  reg  [14:0] next_wr;
  reg  [14:0] next_rd;
  wire [14:0] cap;
  wire [14:0] wwid;
  wire [14:0] rwid;

  assign wwid = {9'h000, wr_width_i};
  assign rwid = {9'h000, rd_width_i};
  // Nine-bit families use the parity bits as well
  assign cap = (wr_width_i == 6'd9 || wr_width_i == 6'd18 ||
                wr_width_i == 6'd36) ? `EBM_CAP_NINE : `EBM_CAP_BIN;

  assign full_o    = (level + wwid) > cap;
  assign empty_o   = level < rwid;
  assign push_ok_o = fifo_mode_i & push_i & ~full_o;
  assign pop_ok_o  = fifo_mode_i & pop_i & ~empty_o;

  always @* begin
    next_wr = {1'b0, wr_ptr_o} + wwid;
    if (next_wr >= cap) begin
      next_wr = next_wr - cap;
    end
    next_rd = {1'b0, rd_ptr_o} + rwid;
    if (next_rd >= cap) begin
      next_rd = next_rd - cap;
    end
    next_level = level;
    if (push_ok_o) begin
      next_level = next_level + wwid;
    end
    if (pop_ok_o) begin
      next_level = next_level - rwid;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_o <= 14'h0000;
      rd_ptr_o <= 14'h0000;
      level    <= 15'h0000;
    end else if (!fifo_mode_i) begin
      wr_ptr_o <= 14'h0000;
      rd_ptr_o <= 14'h0000;
      level    <= 15'h0000;
    end else begin
      if (push_ok_o) begin
        wr_ptr_o <= next_wr[13:0];
      end
      if (pop_ok_o) begin
        rd_ptr_o <= next_rd[13:0];
      end
      level <= next_level;
    end
  end

endmodule

// >>> ebm_chk.sv
// Assertion checker on the block memory ports
`include "ebm_regs.vh"
module ebm_chk (
  input wire               sys_clk_i,
  input wire               rst_b_i,
  input wire               cfg_busy_i,
  input wire               cfg_we_i,
  input wire [1:0]         mode_i,
  input wire               rom_i,
  input wire [2:0]         a_width_i,
  input wire [2:0]         b_width_i,
  input wire               a_out_reg_i,
  input wire               a_en_i,
  input wire               a_we_i,
  input wire               b_en_i,
  input wire [`EBM_DW-1:0] a_rdata_o,
  input wire               fifo_full_o,
  input wire               fifo_empty_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire fifo = (mode_i == `EBM_MODE_FIFO);
  wire wide = (a_width_i >= `EBM_W_X36) && (b_width_i >= `EBM_W_X36);
  sequence s_hold_a;
    a_out_reg_i && !a_en_i && !b_en_i && !cfg_busy_i ##1
    a_out_reg_i && !a_en_i && !b_en_i && !cfg_busy_i ##1
    a_out_reg_i && !a_en_i && !b_en_i && !cfg_busy_i;
  endsequence
  sequence s_rom_idle;
    rom_i && !a_en_i && !cfg_we_i && !a_out_reg_i && $stable(a_width_i);
  endsequence
  a_flags_excl: assert property (
    fifo |-> !(fifo_full_o && fifo_empty_o)) else $error("full and empty");
  a_rst_empty: assert property (
    $rose(rst_b_i) && fifo |-> fifo_empty_o) else $error("not empty");
  a_pop_empty: assert property (
    fifo && fifo_empty_o && b_en_i && !a_en_i |=> fifo_empty_o)
    else $error("pop on empty");
  a_push_full: assert property (
    fifo && fifo_full_o && a_en_i && !b_en_i |=> fifo_full_o)
    else $error("push on full");
  a_push_fills: assert property (
    fifo && wide && fifo_empty_o && a_en_i && a_we_i && !cfg_busy_i && !rom_i
    |=> !fifo_empty_o) else $error("push lost");
  a_busy_ignored: assert property (
    fifo && cfg_busy_i && fifo_empty_o |=> fifo_empty_o)
    else $error("push in config");
  a_reg_hold: assert property (
    s_hold_a |-> $stable(a_rdata_o)) else $error("reg output moved");
  a_rom_hold: assert property (
    s_rom_idle [*3] |-> $stable(a_rdata_o)) else $error("rom data moved");
endmodule
bind ebm_block_memory ebm_chk u_chk (
  .sys_clk_i, .rst_b_i, .cfg_busy_i, .cfg_we_i, .mode_i, .rom_i,
  .a_width_i, .b_width_i, .a_out_reg_i, .a_en_i, .a_we_i, .b_en_i,
  .a_rdata_o, .fifo_full_o, .fifo_empty_o);

// >>> ebm_user.sv
// Model of the user logic driving one memory port
`include "ebm_regs.vh"
module ebm_user (
  input  wire                sys_clk_i,
  output logic               en_o    = 1'h0,
  output logic               we_o    = 1'h0,
  output logic [`EBM_AW-1:0] addr_o  = 13'h0,
  output logic [`EBM_DW-1:0] wdata_o = 36'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Request held over its taking edge, then released with scrambled lines
  task automatic op(input logic we, input logic [12:0] a,
                    input logic [35:0] d);
    @(negedge sys_clk_i);
    en_o = 1'h1;
    we_o = we;
    addr_o = a;
    wdata_o = d;
    @(negedge sys_clk_i);
    en_o = 1'h0;
    we_o = 1'h0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

// >>> tb.sv
// Self-checking testbench for the block memory
`include "ebm_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [35:0] PAT = 36'h5_a3c9_17e2;
  localparam logic [35:0] DAT = 36'h9_8765_4321;
  logic sys_clk_i = 1'h0, rst_b_i = 1'h0, cfg_busy_i = 1'h0, cfg_we_i = 1'h0;
  logic cfg_bit_i = 1'h0, rom_i = 1'h0, a_out_reg_i = 1'h0, b_out_reg_i = 1'h0;
  logic [13:0] cfg_addr_i = 14'h0;
  logic [1:0]  mode_i = 2'h0;
  logic [2:0]  a_width_i = 3'h5, b_width_i = 3'h5;
  wire         a_en_i, a_we_i, b_en_i, b_we_i, fifo_full_o, fifo_empty_o;
  wire [12:0]  a_addr_i, b_addr_i;
  wire [35:0]  a_wdata_i, b_wdata_i, a_rdata_o, b_rdata_o;
  int          errors = 0;
  int          checked = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  ebm_user u_a (.sys_clk_i, .en_o(a_en_i), .we_o(a_we_i), .addr_o(a_addr_i),
                .wdata_o(a_wdata_i));
  ebm_user u_b (.sys_clk_i, .en_o(b_en_i), .we_o(b_we_i), .addr_o(b_addr_i),
                .wdata_o(b_wdata_i));
  ebm_block_memory dut (.sys_clk_i, .rst_b_i, .cfg_busy_i, .cfg_we_i,
    .cfg_addr_i, .cfg_bit_i, .mode_i, .rom_i, .a_width_i, .b_width_i,
    .a_out_reg_i, .b_out_reg_i, .a_en_i, .a_we_i, .a_addr_i, .a_wdata_i,
    .b_en_i, .b_we_i, .b_addr_i, .b_wdata_i, .a_rdata_o, .b_rdata_o,
    .fifo_full_o, .fifo_empty_o);
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    chk({35'h0, got}, {35'h0, exp});
  endtask
  task automatic complete_run;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Preload word 1 in configuration, then a refused write as a ROM
  task automatic t_rom;
    cfg_busy_i = 1'h1;
    for (int i = 0; i < 36; i++) begin
      @(negedge sys_clk_i);
      cfg_we_i = 1'h1;
      cfg_addr_i = 14'(36 + i);
      cfg_bit_i = PAT[i];
    end
    @(negedge sys_clk_i);
    cfg_we_i = 1'h0;
    cfg_busy_i = 1'h0;
    rom_i = 1'h1;
    u_a.op(1'h1, 13'h1, ~PAT);
    repeat (2) @(negedge sys_clk_i);
    u_a.op(1'h0, 13'h1, 36'h0);
    chk(a_rdata_o, PAT);
    repeat (4) @(negedge sys_clk_i);
    rom_i = 1'h0;
  endtask
  // Wide write on A, narrow reads on B; B write refused in pseudo dual
  task automatic t_map;
    mode_i = `EBM_MODE_PDP;
    b_width_i = `EBM_W_X9;
    u_a.op(1'h1, 13'h2, DAT);
    u_b.op(1'h1, 13'h8, 36'hf_ffff_ffff);
    @(negedge sys_clk_i);
    for (int k = 0; k < 4; k++) begin
      u_b.op(1'h0, 13'(8 + k), 36'h0);
      chk(b_rdata_o, {27'h0, DAT[9*k +: 9]});
    end
  endtask
  // Registered output lags the flow output by one clock
  task automatic t_reg;
    mode_i = `EBM_MODE_SP;
    a_out_reg_i = 1'h1;
    u_a.op(1'h0, 13'h1, 36'h0);
    @(negedge sys_clk_i);
    u_a.op(1'h0, 13'h2, 36'h0);
    chk(a_rdata_o, PAT);
    @(negedge sys_clk_i);
    chk(a_rdata_o, DAT);
    repeat (4) @(negedge sys_clk_i);
    a_out_reg_i = 1'h0;
  endtask
  // True dual-port: B writes, both ports capped at 18 bits
  task automatic t_tdp;
    mode_i = `EBM_MODE_TDP;
    b_width_i = `EBM_W_X36;
    u_b.op(1'h1, 13'h10, 36'hf_ffff_ffff);
    u_a.op(1'h0, 13'h10, 36'h0);
    chk(a_rdata_o, {18'h0, 18'h3_ffff});
  endtask
  // Fill to full, refused pushes and pops, drain in order, reset mid-run
  task automatic t_fifo;
    mode_i = `EBM_MODE_FIFO;
    b_width_i = `EBM_W_X36;
    @(negedge sys_clk_i);
    chk_f(fifo_empty_o, 1'h1);
    chk_f(fifo_full_o, 1'h0);
    u_b.op(1'h0, 13'h0, 36'h0);
    chk_f(fifo_empty_o, 1'h1);
    cfg_busy_i = 1'h1;
    u_a.op(1'h1, 13'h0, 36'h7);
    cfg_busy_i = 1'h0;
    chk_f(fifo_empty_o, 1'h1);
    for (int i = 0; i < 256; i++) u_a.op(1'h1, 13'h0, 36'(i));
    chk_f(fifo_full_o, 1'h1);
    u_a.op(1'h1, 13'h0, 36'hf_ffff_ffff);
    for (int i = 0; i < 256; i++) begin
      u_b.op(1'h0, 13'h0, 36'h0);
      chk(b_rdata_o, 36'(i));
    end
    chk_f(fifo_empty_o, 1'h1);
    u_a.op(1'h1, 13'h0, 36'h1);
    rst_b_i = 1'h0;
    @(negedge sys_clk_i);
    rst_b_i = 1'h1;
    chk_f(fifo_empty_o, 1'h1);
  endtask
  initial begin
    #100us;
    errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge sys_clk_i);
    rst_b_i = 1'h1;
    t_rom();
    t_map();
    t_reg();
    t_tdp();
    t_fifo();
    complete_run();
  end
endmodule
